//--- rtl/aidet_pkg.sv
package aidet_pkg;

   // ------------------------------------------------------------
   // Field widths and encodings
   // ------------------------------------------------------------
   localparam int          THS_W        = 6;
   localparam int          SAMPLE_W     = 16;
   localparam int          CNT_W        = 14;
   localparam logic [1:0]  ACT_NONE     = 2'h0;
   localparam logic [1:0]  ACT_KEEP     = 2'h1;
   localparam logic [1:0]  ACT_SLEEP    = 2'h2;
   localparam logic [1:0]  ACT_OFF      = 2'h3;
   localparam logic [2:0]  MODE_LP1     = 3'h4;
   localparam logic [1:0]  GYRO_NORMAL  = 2'h0;
   localparam logic [1:0]  GYRO_SLEEP   = 2'h1;
   localparam logic [1:0]  GYRO_OFF     = 2'h2;
   localparam logic [CNT_W-1:0] SHORT_SLEEP = 14'h0010;
   localparam int          SLEEP_UNIT_SH = 9;
   localparam int          WEIGHT_MAX   = 5;
   localparam logic        FILTER_RST   = 1'b0;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] x;
      logic signed [SAMPLE_W-1:0] y;
      logic signed [SAMPLE_W-1:0] z;
   } aidet_axes_t;

   typedef struct packed {
      logic [2:0] power_mode;
      logic [3:0] rate;
      logic [1:0] gyro;
   } aidet_power_t;

   typedef enum logic [1:0] {
      S_ACTIVE   = 2'b01,
      S_INACTIVE = 2'b10
   } aidet_state_t;

endpackage

//--- rtl/aidet_axis_cmp.sv
`timescale 1ns/1ps
module aidet_axis_cmp
   import aidet_pkg::*;
(
   input  wire aidet_axes_t   axes,
   input  wire logic [THS_W-1:0] ths,
   input  wire logic [2:0]    weight,
   output logic               all_below,
   output logic               any_above
);

   logic [SAMPLE_W+THS_W-1:0] lim;
   logic ax, ay, az;

   function automatic logic [SAMPLE_W-1:0] mag(input logic signed [SAMPLE_W-1:0] v);
      mag = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : SAMPLE_W'(v);
   endfunction

   always_comb
   begin
      // weight scaling, codes above 101 saturate
      lim = (SAMPLE_W+THS_W)'(ths) << ((weight > 3'(WEIGHT_MAX)) ? WEIGHT_MAX : int'(weight));
      ax = (SAMPLE_W+THS_W)'(mag(axes.x)) > lim;
      ay = (SAMPLE_W+THS_W)'(mag(axes.y)) > lim;
      az = (SAMPLE_W+THS_W)'(mag(axes.z)) > lim;
      any_above = ax | ay | az;
      all_below = ~any_above;
   end

endmodule

//--- rtl/aidet_top.sv
`timescale 1ns/1ps
// Function
// - codes 01,10,11 force accel LP1 at inactive rate; gyro keep, sleep, off.
// - code 00 flags state changes only, no power or rate change.
// - filter select 0 slope path, 1 high-pass path, reset 0.
// - threshold is 6-bit unsigned.
// - weight sets LSB, 7.8125 mg doubling up to 250 mg saturated.
// - magnitude compared so both signs act alike.
// - enough quiet samples force accel LP1 under codes 01,10,11, user fields untouched.
// - inactive rate select 00..11 maps to four low rates.
// - sleep duration unit 512 samples, zero means 16 samples.
// - change event lasts one sample period when not latched.
// - any axis above for activity duration restores user settings.
// - activity duration counts samples, zero means first sample.
// - per-pin route bits; flag shown in both status views.
// - flag pulsed unless latch enabled, routed to a pin and state-on-pin off.
// - sleep state bit shows current state always.
// - state-on-pin drives state level on routed pins, never latched.
module aidet_top
   import aidet_pkg::*;
(
   input  wire logic          MCLK,
   input  wire logic          ARST_N,
   input  wire logic          SAMPLE_VALID,
   input  wire aidet_axes_t   SLOPE_DATA,
   input  wire aidet_axes_t   HIPASS_DATA,
   input  wire logic          INTERRUPT_FUNCTIONS_ENABLE,
   input  wire logic [1:0]    INACTIVITY_ACTION_SEL,
   input  wire logic [1:0]    INACTIVE_RATE_SEL,
   input  wire logic          FILTER_PATH_SEL,
   input  wire logic [THS_W-1:0] MOTION_THRESHOLD,
   input  wire logic [2:0]    THRESHOLD_WEIGHT,
   input  wire logic [3:0]    SLEEP_DURATION,
   input  wire logic [1:0]    ACTIVITY_DURATION,
   input  wire logic          PIN1_STATE_CHANGE_ROUTE,
   input  wire logic          PIN2_STATE_CHANGE_ROUTE,
   input  wire logic          LATCH_ENABLE,
   input  wire logic          STATE_ON_PIN,
   input  wire logic          STATUS_READ,
   input  wire aidet_power_t  USER_POWER,
   output aidet_power_t       EFFECTIVE_POWER,
   output logic               STATE_CHANGE_FLAG,
   output logic               SLEEP_STATE,
   output logic               INTERRUPT_PIN_ONE,
   output logic               INTERRUPT_PIN_TWO
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ------------------------------------------------------------
   // Compare
   // ------------------------------------------------------------
   aidet_axes_t sel_axes;
   logic        all_below, any_above;

   assign sel_axes = FILTER_PATH_SEL ? HIPASS_DATA : SLOPE_DATA;

   aidet_axis_cmp u_cmp (
      .axes      (sel_axes),
      .ths       (MOTION_THRESHOLD),
      .weight    (THRESHOLD_WEIGHT),
      .all_below (all_below),
      .any_above (any_above)
   );

   // ------------------------------------------------------------
   // Detector
   // ------------------------------------------------------------
   aidet_state_t     state_q, state_d;
   logic [CNT_W-1:0] quiet_q, quiet_d, busy_q, busy_d, quiet_need;
   logic             pulse_q, pulse_d, latch_q, latch_d, change;
   logic             enabled, routed, latching;

   assign enabled  = INTERRUPT_FUNCTIONS_ENABLE;
   assign routed   = PIN1_STATE_CHANGE_ROUTE | PIN2_STATE_CHANGE_ROUTE;
   assign latching = LATCH_ENABLE & routed & ~STATE_ON_PIN;

   always_comb
   begin
      quiet_need = (SLEEP_DURATION == 4'h0) ? SHORT_SLEEP
                 : CNT_W'({SLEEP_DURATION, {SLEEP_UNIT_SH{1'b0}}});
      state_d = state_q;
      quiet_d = quiet_q;
      busy_d  = busy_q;
      pulse_d = pulse_q;
      latch_d = latch_q;
      change  = 1'b0;
      if (!enabled)
      begin
         state_d = S_ACTIVE;
         quiet_d = '0;
         busy_d  = '0;
         pulse_d = 1'b0;
      end
      else if (SAMPLE_VALID)
      begin
         // pulse ends after one sample period
         pulse_d = 1'b0;
         case (state_q)
            S_ACTIVE:
            begin
               quiet_d = all_below ? quiet_q + 1'b1 : '0;
               // enter inactivity after enough quiet samples
               if (all_below && (quiet_q + 1'b1 >= quiet_need))
               begin
                  state_d = S_INACTIVE;
                  quiet_d = '0;
                  busy_d  = '0;
                  change  = 1'b1;
               end
            end
            S_INACTIVE:
            begin
               busy_d = any_above ? busy_q + 1'b1 : '0;
               // activity after duration, 00 means first sample
               if (any_above && (busy_q >= CNT_W'(ACTIVITY_DURATION)))
               begin
                  state_d = S_ACTIVE;
                  busy_d  = '0;
                  quiet_d = '0;
                  change  = 1'b1;
               end
            end
            default:
            begin
               state_d = S_ACTIVE;
            end
         endcase
         if (change)
            pulse_d = 1'b1;
      end
      if (STATUS_READ || !latching)
         latch_d = 1'b0;
      if (change && latching)
         latch_d = 1'b1;
   end

   always_ff @(posedge MCLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= S_ACTIVE;
         quiet_q <= '0;
         busy_q  <= '0;
         pulse_q <= 1'b0;
         latch_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         quiet_q <= quiet_d;
         busy_q  <= busy_d;
         pulse_q <= pulse_d;
         latch_q <= latch_d;
      end
   end

   // ------------------------------------------------------------
   // Power override and outputs
   // ------------------------------------------------------------
   aidet_power_t pwr_d, pwr_q;
   logic flag_d, flag_q, pin1_d, pin1_q, pin2_d, pin2_q, sleep_d, sleep_q, ev;

   always_comb
   begin
      pwr_d = USER_POWER;
      // override only in inactivity with a power action
      if (state_q == S_INACTIVE && INACTIVITY_ACTION_SEL != ACT_NONE)
      begin
         pwr_d.power_mode = MODE_LP1;
         // inactive rate code carried in the rate field
         pwr_d.rate = {2'h0, INACTIVE_RATE_SEL};
         case (INACTIVITY_ACTION_SEL)
            ACT_SLEEP: pwr_d.gyro = GYRO_SLEEP;
            ACT_OFF:   pwr_d.gyro = GYRO_OFF;
            default:   pwr_d.gyro = USER_POWER.gyro;
         endcase
      end
      sleep_d = (state_q == S_INACTIVE);
      ev      = pulse_q | latch_q;
      // flag in status; routed pins carry flag, or state level when state-on-pin set
      flag_d  = ev;
      pin1_d  = PIN1_STATE_CHANGE_ROUTE & (STATE_ON_PIN ? sleep_d : ev);
      pin2_d  = PIN2_STATE_CHANGE_ROUTE & (STATE_ON_PIN ? sleep_d : ev);
   end

   // Registered so outputs never glitch on comparator settling
   always_ff @(posedge MCLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pwr_q   <= '0;
         flag_q  <= 1'b0;
         sleep_q <= 1'b0;
         pin1_q  <= 1'b0;
         pin2_q  <= 1'b0;
      end
      else
      begin
         pwr_q   <= pwr_d;
         flag_q  <= flag_d;
         sleep_q <= sleep_d;
         pin1_q  <= pin1_d;
         pin2_q  <= pin2_d;
      end
   end

   assign EFFECTIVE_POWER   = pwr_q;
   assign STATE_CHANGE_FLAG = flag_q;
   assign SLEEP_STATE       = sleep_q;
   assign INTERRUPT_PIN_ONE = pin1_q;
   assign INTERRUPT_PIN_TWO = pin2_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_pin_level: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      STATE_ON_PIN && PIN1_STATE_CHANGE_ROUTE |=> INTERRUPT_PIN_ONE == $past(sleep_d))
      else $error("pin one level wrong");
   a_pin2_level: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      STATE_ON_PIN && PIN2_STATE_CHANGE_ROUTE |=> INTERRUPT_PIN_TWO == $past(sleep_d))
      else $error("pin two level wrong");
   // Output flops leave reset one edge after the rst_n_q release edge, so that edge is skipped
   a_no_override: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      rst_n_q && INACTIVITY_ACTION_SEL == ACT_NONE |=> EFFECTIVE_POWER == $past(USER_POWER))
      else $error("override with action 00");
   a_lp1_inact: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      state_q == S_INACTIVE && INACTIVITY_ACTION_SEL != ACT_NONE
      |=> EFFECTIVE_POWER.power_mode == MODE_LP1)
      else $error("not low power when inactive");
   a_pulse_ends: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      pulse_q && SAMPLE_VALID && !change |=> !pulse_q)
      else $error("pulse too long");
   a_latch_hold: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      latch_q && latching && !STATUS_READ |=> latch_q)
      else $error("latch lost");
   a_sleep_show: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      1'b1 |=> SLEEP_STATE == ($past(state_q) == S_INACTIVE))
      else $error("sleep state mismatch");
   a_wake_fast: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      enabled && state_q == S_INACTIVE && SAMPLE_VALID && any_above
      && ACTIVITY_DURATION == 2'h0 |=> state_q == S_ACTIVE)
      else $error("no wake on first sample");
   a_quiet_reset: assert property (@(posedge MCLK) disable iff (!rst_n_q)
      enabled && state_q == S_ACTIVE && SAMPLE_VALID && any_above |=> quiet_q == '0)
      else $error("quiet count not restarted");

endmodule

//--- tb/aidet_sensor_model.sv
`timescale 1ns/1ps
module aidet_sensor_model
   import aidet_pkg::*;
#(
   parameter int PER = 4
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] slope_mag,
   input  wire logic [15:0] hp_mag,
   output logic             valid,
   output aidet_axes_t      slope,
   output aidet_axes_t      hipass
);
   // ----------------------------------------
   // Sample source, sign flips every sample
   // ----------------------------------------
   int   cnt;
   logic neg;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt    <= 0;
         neg    <= 1'b0;
         valid  <= 1'b0;
         slope  <= '0;
         hipass <= '0;
      end
      else if (cnt == PER - 1)
      begin
         cnt    <= 0;
         neg    <= ~neg;
         valid  <= 1'b1;
         slope  <= neg ? {-slope_mag, slope_mag, -slope_mag} : {slope_mag, -slope_mag, slope_mag};
         hipass <= neg ? {-hp_mag, hp_mag, -hp_mag} : {hp_mag, -hp_mag, hp_mag};
      end
      else
      begin
         // Stale data is scrambled so nothing relies on it between samples
         cnt    <= cnt + 1;
         valid  <= 1'b0;
         slope  <= ~slope;
         hipass <= ~hipass;
      end
   end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import aidet_pkg::*;
   logic         mclk, arst_n, en, lat, sop, rd, r1, r2, fsel, valid;
   logic [1:0]   act, rsel, adur;
   logic [2:0]   wgt;
   logic [3:0]   sdur;
   logic [5:0]   ths;
   logic [15:0]  smag, hmag;
   aidet_axes_t  sl, hp;
   aidet_power_t upw, epw;
   logic         flag, slp, p1, p2;
   int           error_cnt, n_tests;

   aidet_top i_aidet_top (.MCLK(mclk), .ARST_N(arst_n), .SAMPLE_VALID(valid), .SLOPE_DATA(sl),
      .HIPASS_DATA(hp), .INTERRUPT_FUNCTIONS_ENABLE(en), .INACTIVITY_ACTION_SEL(act),
      .INACTIVE_RATE_SEL(rsel), .FILTER_PATH_SEL(fsel), .MOTION_THRESHOLD(ths),
      .THRESHOLD_WEIGHT(wgt), .SLEEP_DURATION(sdur), .ACTIVITY_DURATION(adur),
      .PIN1_STATE_CHANGE_ROUTE(r1), .PIN2_STATE_CHANGE_ROUTE(r2), .LATCH_ENABLE(lat),
      .STATE_ON_PIN(sop), .STATUS_READ(rd), .USER_POWER(upw), .EFFECTIVE_POWER(epw),
      .STATE_CHANGE_FLAG(flag), .SLEEP_STATE(slp), .INTERRUPT_PIN_ONE(p1),
      .INTERRUPT_PIN_TWO(p2));
   aidet_sensor_model i_aidet_sensor_model (.clk(mclk), .rst_n(arst_n), .slope_mag(smag),
      .hp_mag(hmag), .valid(valid), .slope(sl), .hipass(hp));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(string nm, logic [8:0] got, logic [8:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Selected path quiet or loud, the other path the opposite
   task automatic samp(int n, bit loud);
      logic [15:0] lim;
      logic [15:0] m;
      logic [15:0] o;
      lim  = 16'(ths) << ((wgt > 3'h5) ? 3'h5 : wgt);
      m    = loud ? lim + 16'h1 : lim - 16'h1;
      o    = loud ? 16'h0 : lim + 16'h1;
      smag = fsel ? o : m;
      hmag = fsel ? m : o;
      repeat (n) @(posedge mclk iff valid);
      repeat (2) @(negedge mclk);
   endtask

   function automatic logic [8:0] exp_pwr(logic s);
      aidet_power_t p;
      p = upw;
      if (s && act != ACT_NONE)
      begin
         p.power_mode = MODE_LP1;
         p.rate = {2'h0, rsel};
         p.gyro = (act == ACT_SLEEP) ? GYRO_SLEEP : (act == ACT_OFF) ? GYRO_OFF : upw.gyro;
      end
      return p;
   endfunction

   task automatic st(logic s);
      chk("sleep_state", slp, s);
      chk("power", epw, exp_pwr(s));
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog, sequence
   // ----------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      print_verdict();
   end

   initial
   begin
      {arst_n, lat, sop, rd, r2, fsel, act, rsel, adur, wgt, sdur, ths} = '0;
      {smag, hmag} = '0;
      upw = '{3'h2, 4'h8, GYRO_NORMAL};
      error_cnt = 0;
      n_tests = 0;
      en = 1'b1;
      r1 = 1'b1;
      repeat (16) @(negedge mclk);
      arst_n = 1'b1;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < 8; i++)
      begin
         act = i[1:0];
         rsel = ~i[1:0];
         wgt = i[2:0];
         fsel = i[0];
         ths = 6'(8 * i + 7);
         samp(15, 0);
         st(0);
         samp(1, 0);
         st(1);
         chk("flag", flag, 1);
         chk("pin1", p1, 1);
         chk("pin2", p2, 0);
         samp(1, 0);
         chk("flag", flag, 0);
         samp(1, 1);
         st(0);
         chk("flag", flag, 1);
      end
      samp(10, 0);
      samp(1, 1);
      samp(15, 0);
      st(0);
      samp(1, 0);
      st(1);
      adur = 2'h3;
      samp(3, 1);
      samp(1, 0);
      samp(3, 1);
      st(1);
      samp(1, 1);
      st(0);
      sdur = 4'h1;
      adur = 2'h0;
      samp(511, 0);
      st(0);
      samp(1, 0);
      st(1);
      samp(1, 1);
      sdur = 4'h0;
      lat = 1'b1;
      samp(18, 0);
      chk("flag", flag, 1);
      chk("pin1", p1, 1);
      rd = 1'b1;
      @(negedge mclk);
      rd = 1'b0;
      repeat (2) @(negedge mclk);
      chk("flag", flag, 0);
      chk("pin1", p1, 0);
      r1 = 1'b0;
      samp(2, 1);
      chk("flag", flag, 0);
      sop = 1'b1;
      r2 = 1'b1;
      samp(18, 0);
      chk("pin2", p2, 1);
      chk("pin1", p1, 0);
      samp(1, 1);
      chk("pin2", p2, 0);
      r1 = 1'b1;
      samp(18, 0);
      chk("pin1", p1, 1);
      en = 1'b0;
      samp(40, 0);
      st(0);
      print_verdict();
   end
endmodule
